// File: inc/sdlcfg_params.svh
// Offsets, field positions, reset values and seed constants of the
// modulator configuration and lock-detect control registers.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SDLCFG_PARAMS_SVH
`define SDLCFG_PARAMS_SVH

// ============================================================
// Register offsets and reset values
`define SDLCFG_ADDR_MOD 8'h06
`define SDLCFG_ADDR_LKD 8'h07
`define SDLCFG_MOD_RST 24'h200B4A
`define SDLCFG_LKD_RST 24'h00014D

// ============================================================
// Modulator configuration fields
`define SDLCFG_SEED_HI 1
`define SDLCFG_SEED_LO 0
`define SDLCFG_SKIP_BIT 7
`define SDLCFG_SEEDLD_BIT 8
`define SDLCFG_CORE_BIT 11

// ============================================================
// Lock-detect control fields
`define SDLCFG_TGT_HI 2
`define SDLCFG_TGT_LO 0
`define SDLCFG_LKON_BIT 3
`define SDLCFG_SRC_BIT 6
`define SDLCFG_LEN_HI 9
`define SDLCFG_LEN_LO 7
`define SDLCFG_SPD_HI 11
`define SDLCFG_SPD_LO 10
`define SDLCFG_RELOCK_BIT 13

// ============================================================
// Seed values
`define SDLCFG_SEED_ZERO 24'h000000
`define SDLCFG_SEED_LSB 24'h000001
`define SDLCFG_SEED_TWO 24'hB29D08
`define SDLCFG_SEED_THREE 24'h50F1CD

// ============================================================
// Required consecutive in-window counts per code
`define SDLCFG_CNT0 16'h0005
`define SDLCFG_CNT1 16'h0020
`define SDLCFG_CNT2 16'h0060
`define SDLCFG_CNT3 16'h0100
`define SDLCFG_CNT4 16'h0200
`define SDLCFG_CNT5 16'h0800
`define SDLCFG_CNT6 16'h2000
`define SDLCFG_CNT7 16'hFFFF

`endif

// File: inc/sdlcfg_pkg.sv
// Types and decode functions shared by the configuration block.
// Assumes sdlcfg_params.svh is on the include path.
`include "sdlcfg_params.svh"

package sdlcfg_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [23:0] data;
    } sdlcfg_req_t;

    typedef struct packed {
        logic [2:0] target_code;
        logic on;
        logic src;
        logic [2:0] len;
        logic [1:0] speed;
    } sdlcfg_lkcfg_t;

    function automatic logic [23:0] sdlcfg_seed_of(input logic [1:0] code);
        case (code)
            2'h0: sdlcfg_seed_of = `SDLCFG_SEED_ZERO;
            2'h1: sdlcfg_seed_of = `SDLCFG_SEED_LSB;
            2'h2: sdlcfg_seed_of = `SDLCFG_SEED_TWO;
            default: sdlcfg_seed_of = `SDLCFG_SEED_THREE;
        endcase
    endfunction

    function automatic logic [15:0] sdlcfg_target_of(input logic [2:0] code);
        case (code)
            3'h0: sdlcfg_target_of = `SDLCFG_CNT0;
            3'h1: sdlcfg_target_of = `SDLCFG_CNT1;
            3'h2: sdlcfg_target_of = `SDLCFG_CNT2;
            3'h3: sdlcfg_target_of = `SDLCFG_CNT3;
            3'h4: sdlcfg_target_of = `SDLCFG_CNT4;
            3'h5: sdlcfg_target_of = `SDLCFG_CNT5;
            3'h6: sdlcfg_target_of = `SDLCFG_CNT6;
            default: sdlcfg_target_of = `SDLCFG_CNT7;
        endcase
    endfunction

endpackage

// File: rtl/sdlcfg_lock_count.sv
// Consecutive in-window count tracker that declares lock.
// Assumes sample and hit come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sdlcfg_lock_count
    import sdlcfg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [2:0] target_code_i,
    input wire logic sample_i,
    input wire logic hit_i,
    output logic locked_o
);

    logic [15:0] count_q;
    wire [15:0] target_w = sdlcfg_target_of(target_code_i);
    wire reached_w = count_q >= target_w;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_q <= 16'h0000;
            locked_o <= 1'b0;
        end
        else if (!enable_i)
        begin
            count_q <= 16'h0000;
            locked_o <= 1'b0;
        end
        else if (sample_i && !hit_i)
        begin
            count_q <= 16'h0000;
            locked_o <= 1'b0;
        end
        else if (sample_i && !reached_w)
        begin
            count_q <= count_q + 16'h0001;
            locked_o <= (count_q + 16'h0001) >= target_w;
        end
    end

    lock_miss_a: assert property (@(posedge clock_i) disable iff (rst_i)
        enable_i && sample_i && !hit_i |=> !locked_o && count_q == 16'h0000)
        else $error("miss did not clear lock");

    lock_rise_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(locked_o) |-> $past(count_q) + 16'h0001 == $past(target_w))
        else $error("lock declared at wrong count");

    lock_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !enable_i |=> !locked_o)
        else $error("lock while detector off");

endmodule // sdlcfg_lock_count

`default_nettype wire

// File: rtl/sdlcfg_top.sv
// Modulator configuration and lock-detect control registers with the
// seed transfer, calibration trigger, lock detector and relock logic.
// Assumes serial-port requests and frequency writes on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdlcfg_params.svh"

module sdlcfg_top
    import sdlcfg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire sdlcfg_req_t req_i,
    input wire logic int_write_i,
    input wire logic frac_write_i,
    input wire logic ref_edge_i,
    input wire logic vco_edge_i,
    input wire logic oneshot_hit_i,
    output logic [23:0] rdata_o,
    output logic rvalid_o,
    output logic [23:0] seed_o,
    output logic modulator_output_skip_o,
    output logic sigma_delta_core_on_o,
    output logic frac_path_used_o,
    output logic autocal_start_o,
    output logic locked_o
);

    // ============================================================
    // Register storage
    logic [23:0] modulator_config_q;
    logic [23:0] lock_detect_control_q;

    wire sel_mod = req_i.addr == `SDLCFG_ADDR_MOD;
    wire sel_lkd = req_i.addr == `SDLCFG_ADDR_LKD;
    wire wr_mod = req_i.wr & sel_mod;
    wire wr_lkd = req_i.wr & sel_lkd;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            modulator_config_q <= `SDLCFG_MOD_RST;
            lock_detect_control_q <= `SDLCFG_LKD_RST;
        end
        else
        begin
            if (wr_mod)
                modulator_config_q <= req_i.data;
            if (wr_lkd)
                lock_detect_control_q <= req_i.data;
        end
    end

    // ============================================================
    // Read path, unmapped offsets return zero
    wire [23:0] read_mux;

    assign read_mux = sel_mod ? modulator_config_q
                    : sel_lkd ? lock_detect_control_q
                    : 24'h000000;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 24'h000000;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= req_i.rd;
            if (req_i.rd)
                rdata_o <= read_mux;
        end
    end

    // ============================================================
    // Modulator field decode
    wire [1:0] seed_code =
        modulator_config_q[`SDLCFG_SEED_HI:`SDLCFG_SEED_LO];
    wire seed_load_en = modulator_config_q[`SDLCFG_SEEDLD_BIT];
    wire core_on = modulator_config_q[`SDLCFG_CORE_BIT];
    wire skip_on = modulator_config_q[`SDLCFG_SKIP_BIT];

    // Software keeps bypass and bits 10 to 8 consistent with the mode
    assign sigma_delta_core_on_o = core_on;
    assign modulator_output_skip_o = skip_on;
    assign frac_path_used_o = core_on & ~skip_on;

    // ============================================================
    // Calibration trigger selects the write that counts as a change
    wire freq_change = core_on ? frac_write_i : int_write_i;

    // ============================================================
    // Seed transfer into the modulator
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            seed_o <= `SDLCFG_SEED_TWO;
        else if (freq_change && seed_load_en)
            seed_o <= sdlcfg_seed_of(seed_code);
    end

    // ============================================================
    // Lock detector
    sdlcfg_lkcfg_t lk_cfg;
    logic win_sample;
    logic win_hit;

    assign lk_cfg.target_code =
        lock_detect_control_q[`SDLCFG_TGT_HI:`SDLCFG_TGT_LO];
    assign lk_cfg.on = lock_detect_control_q[`SDLCFG_LKON_BIT];
    assign lk_cfg.src = lock_detect_control_q[`SDLCFG_SRC_BIT];
    assign lk_cfg.len =
        lock_detect_control_q[`SDLCFG_LEN_HI:`SDLCFG_LEN_LO];
    assign lk_cfg.speed =
        lock_detect_control_q[`SDLCFG_SPD_HI:`SDLCFG_SPD_LO];

    sdlcfg_window u_window (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cfg_i(lk_cfg),
        .ref_edge_i(ref_edge_i),
        .vco_edge_i(vco_edge_i),
        .oneshot_hit_i(oneshot_hit_i),
        .sample_o(win_sample),
        .hit_o(win_hit)
    );

    sdlcfg_lock_count u_lock_count (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(lk_cfg.on),
        .target_code_i(lk_cfg.target_code),
        .sample_i(win_sample),
        .hit_i(win_hit),
        .locked_o(locked_o)
    );

    // ============================================================
    // Single relock attempt after loss of lock
    wire relock_on_loss = lock_detect_control_q[`SDLCFG_RELOCK_BIT];
    logic locked_prev_q;
    logic relock_used_q;
    wire lock_lost = locked_prev_q & ~locked_o & lk_cfg.on;
    wire relock_fire = lock_lost & relock_on_loss & ~relock_used_q;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            locked_prev_q <= 1'b0;
            relock_used_q <= 1'b0;
        end
        else
        begin
            locked_prev_q <= locked_o;
            // A new lock re-arms the single attempt
            if (relock_fire)
                relock_used_q <= 1'b1;
            else if (locked_o)
                relock_used_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            autocal_start_o <= 1'b0;
        else
            autocal_start_o <= freq_change | relock_fire;
    end

    // ============================================================
    // Checks
    seed_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !(freq_change && seed_load_en) |=> $stable(seed_o))
        else $error("seed changed without frequency change");

    seed_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
        freq_change && seed_load_en && seed_code == 2'h3
        |=> seed_o == `SDLCFG_SEED_THREE)
        else $error("seed code three not loaded");

    cal_int_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !core_on && int_write_i |=> autocal_start_o)
        else $error("integer write did not calibrate");

    cal_frac_a: assert property (@(posedge clock_i) disable iff (rst_i)
        core_on && !frac_write_i && !relock_fire |=> !autocal_start_o)
        else $error("calibration without fractional write");

    core_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_mod && !req_i.data[`SDLCFG_CORE_BIT]
        |=> !sigma_delta_core_on_o && !frac_path_used_o)
        else $error("core still on after disable write");

    skip_path_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_mod && req_i.data[`SDLCFG_SKIP_BIT]
        |=> !frac_path_used_o && modulator_output_skip_o)
        else $error("modulator output used while bypassed");

    readback_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_lkd ##1 (req_i.rd && sel_lkd && !req_i.wr)
        |=> rvalid_o && rdata_o == $past(req_i.data, 2))
        else $error("lock-detect register readback wrong");

    relock_once_a: assert property (@(posedge clock_i) disable iff (rst_i)
        relock_fire |=> !relock_fire [*2])
        else $error("relock attempted twice in a row");

endmodule // sdlcfg_top

`default_nettype wire

// File: rtl/sdlcfg_window.sv
// Lock window timer: digital programmable window or analog one-shot.
// Assumes reference, divided-VCO and one-shot inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module sdlcfg_window
    import sdlcfg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire sdlcfg_lkcfg_t cfg_i,
    input wire logic ref_edge_i,
    input wire logic vco_edge_i,
    input wire logic oneshot_hit_i,
    output logic sample_o,
    output logic hit_o
);

    // ============================================================
    // Input synchronisers and edge detection
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;
    wire ref_rise = sync2_q[0] & ~prev_q[0];
    wire vco_rise = sync2_q[1] & ~prev_q[1];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 2'h0;
        end
        else
        begin
            sync1_q <= {oneshot_hit_i, vco_edge_i, ref_edge_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[1:0];
        end
    end

    // ============================================================
    // Timer rate divider, one half-cycle unit per tick
    logic [2:0] div_q;
    wire [2:0] div_mask = 3'((4'h1 << cfg_i.speed) - 4'h1);
    wire tick = (div_q & div_mask) == div_mask;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            div_q <= 3'h0;
        else
            div_q <= div_q + 3'h1;
    end

    // ============================================================
    // Digital window, length 2^code half-cycle units
    logic [7:0] half_q;
    logic open_q;
    wire [7:0] limit_w = 8'h01 << cfg_i.len;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            half_q <= 8'h00;
            open_q <= 1'b0;
        end
        else if (ref_rise)
        begin
            half_q <= 8'h00;
            open_q <= 1'b1;
        end
        else if (open_q && tick)
        begin
            half_q <= half_q + 8'h01;
            if (half_q == limit_w - 8'h01)
                open_q <= 1'b0;
        end
    end

    // ============================================================
    // Sample result per divided-VCO count
    wire hit_w = cfg_i.src ? open_q : sync2_q[2];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sample_o <= 1'b0;
            hit_o <= 1'b0;
        end
        else
        begin
            sample_o <= vco_rise;
            hit_o <= hit_w;
        end
    end

    window_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(open_q) |-> $past(half_q) == $past(limit_w) - 8'h01)
        else $error("digital window closed at wrong length");

    window_src_a: assert property (@(posedge clock_i) disable iff (rst_i)
        vco_rise && !cfg_i.src |=> sample_o && hit_o == $past(sync2_q[2]))
        else $error("one-shot result not used as hit");

endmodule // sdlcfg_window

`default_nettype wire

// File: verif/tb_sdlcfg_top.sv
// Self-checking bench for the modulator and lock-detect config block.
// Assumes sdlcfg_pkg is compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_sdlcfg_top
    import sdlcfg_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    sdlcfg_req_t req_i = '0;
    logic int_write_i = 1'b0;
    logic frac_write_i = 1'b0;
    logic ref_edge_i = 1'b0;
    logic vco_edge_i = 1'b0;
    logic oneshot_hit_i = 1'b0;
    logic [23:0] rdata_o;
    logic [23:0] seed_o;
    logic rvalid_o, skip_o, core_o, fpu_o, autocal_o, locked_o;
    int errors = 0;
    int comparisons = 0;
    logic [23:0] rd_q [$];
    logic [23:0] cal_q [$];
    logic [31:0] rng = 32'd82459;
    logic [23:0] cur_seed = 24'hB29D08;
    logic [23:0] seeds [4] = '{24'h000000, 24'h000001, 24'hB29D08, 24'h50F1CD};
    int tgt [4] = '{5, 32, 96, 256};
    int lens [4] = '{7, 0, 2, 2};
    int spds [4] = '{1, 2, 3, 0};
    logic hits [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #12.5 clock_i = ~clock_i;

    sdlcfg_top dut
    (
        .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
        .int_write_i(int_write_i), .frac_write_i(frac_write_i),
        .ref_edge_i(ref_edge_i), .vco_edge_i(vco_edge_i),
        .oneshot_hit_i(oneshot_hit_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .seed_o(seed_o),
        .modulator_output_skip_o(skip_o), .sigma_delta_core_on_o(core_o),
        .frac_path_used_o(fpu_o), .autocal_start_o(autocal_o),
        .locked_o(locked_o)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction

    function automatic logic [23:0] mcfg(input logic [1:0] c,
        input logic skip, input logic ld, input logic core);
        return {12'h000, core, 2'h3, ld, skip, 5'h12, c};
    endfunction

    function automatic logic [23:0] lkd(input logic [2:0] c, input logic on,
        input logic src, input logic [2:0] len, input logic [1:0] spd,
        input logic rl);
        return {10'h000, rl, 1'b0, spd, len, src, 2'h0, on, c};
    endfunction

    task automatic bad(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk_rd(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
            bad("read data differs");
    endtask

    task automatic chk_seed(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
            bad("modulator seed differs");
    endtask

    task automatic chk_lvl(input logic got, input logic exp, input string m);
        comparisons++;
        if (got !== exp)
            bad(m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clock_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clock_i);
        req_i <= '0;
        // Let the written value reach the register outputs
        @(posedge clock_i);
    endtask

    // Write followed by a read of the same word in the next cycle
    task automatic wrrd(input logic [7:0] a, input logic [23:0] d);
        rd_q.push_back(d);
        @(posedge clock_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clock_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 24'h000000};
        @(posedge clock_i);
        req_i <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        rd_q.push_back(exp);
        @(posedge clock_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 24'h000000};
        @(posedge clock_i);
        req_i <= '0;
    endtask

    task automatic freq(input logic is_int, input int n);
        @(posedge clock_i);
        int_write_i <= is_int;
        frac_write_i <= !is_int;
        repeat (n) @(posedge clock_i);
        int_write_i <= 1'b0;
        frac_write_i <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic vp(input logic hit);
        oneshot_hit_i <= hit;
        repeat (3) @(posedge clock_i);
        vco_edge_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        vco_edge_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic pair(input int gap);
        ref_edge_i <= 1'b1;
        repeat (gap) @(posedge clock_i);
        vco_edge_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        ref_edge_i <= 1'b0;
        vco_edge_i <= 1'b0;
        repeat (140) @(posedge clock_i);
    endtask

    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Output watcher
    initial
    begin
        forever
        begin
            @(posedge clock_i);
            if (!rst_i && rvalid_o === 1'b1)
            begin
                if (rd_q.size() == 0)
                    bad("read answer without request");
                else
                    chk_rd(rdata_o, rd_q.pop_front());
            end
            if (!rst_i && autocal_o === 1'b1)
            begin
                if (cal_q.size() == 0)
                    bad("calibration start without cause");
                else
                    chk_seed(seed_o, cal_q.pop_front());
            end
        end
    end

    initial
    begin
        repeat (60000) @(posedge clock_i);
        bad("watchdog expired");
        results();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [7:0] a;
        repeat (2) @(posedge clock_i);
        chk_seed(seed_o, 24'hB29D08);
        chk_lvl(core_o, 1'b1, "core enable after reset");
        chk_lvl(locked_o, 1'b0, "locked during reset");
        rst_i <= 1'b0;
        rd(8'h06, 24'h200B4A);
        rd(8'h07, 24'h00014D);
        for (int i = 0; i < 8; i++)
        begin
            rng = xs(rng);
            wr(8'h06, rng[23:0]);
            rd(8'h06, rng[23:0]);
            rng = xs(rng);
            wrrd(8'h07, rng[23:0]);
            a = rng[31:24];
            if (a == 8'h06 || a == 8'h07)
                a = a ^ 8'h10;
            wr(a, rng[23:0]);
            rd(a, 24'h000000);
        end
        // Seed loading on fractional writes with the core on
        wr(8'h07, lkd(3'h0, 1'b0, 1'b1, 3'h2, 2'h0, 1'b0));
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h06, mcfg(c[1:0], 1'b0, 1'b1, 1'b1));
            cur_seed = seeds[c];
            cal_q.push_back(cur_seed);
            freq(1'b0, 1);
        end
        chk_lvl(fpu_o, 1'b1, "fractional path off");
        wr(8'h06, mcfg(2'h1, 1'b0, 1'b0, 1'b1));
        cal_q.push_back(cur_seed);
        freq(1'b0, 1);
        freq(1'b1, 1);
        wr(8'h06, mcfg(2'h0, 1'b1, 1'b0, 1'b1));
        chk_lvl(skip_o, 1'b1, "skip not set");
        chk_lvl(fpu_o, 1'b0, "skip ignored");
        wr(8'h06, mcfg(2'h0, 1'b1, 1'b1, 1'b0));
        chk_lvl(core_o, 1'b0, "core still on");
        freq(1'b0, 1);
        cur_seed = 24'h000000;
        cal_q.push_back(cur_seed);
        cal_q.push_back(cur_seed);
        freq(1'b1, 2);
        chk_lvl(cal_q.size() == 0, 1'b1, "calibration missing");
        // Consecutive count targets with the analog window result
        wr(8'h07, lkd(3'h0, 1'b1, 1'b0, 3'h2, 2'h0, 1'b0));
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h07, lkd(c[2:0], 1'b1, 1'b0, 3'h2, 2'h0, 1'b0));
            vp(1'b0);
            repeat (tgt[c] - 1) vp(1'b1);
            repeat (6) @(posedge clock_i);
            chk_lvl(locked_o, 1'b0, "lock too early");
            vp(1'b1);
            repeat (6) @(posedge clock_i);
            chk_lvl(locked_o, 1'b1, "lock missing");
        end
        wr(8'h07, lkd(3'h0, 1'b0, 1'b0, 3'h2, 2'h0, 1'b1));
        repeat (6) vp(1'b1);
        chk_lvl(locked_o, 1'b0, "lock while disabled");
        wr(8'h07, lkd(3'h0, 1'b1, 1'b0, 3'h2, 2'h0, 1'b1));
        repeat (5) vp(1'b1);
        repeat (6) @(posedge clock_i);
        chk_lvl(locked_o, 1'b1, "lock missing");
        cal_q.push_back(cur_seed);
        vp(1'b0);
        repeat (6) @(posedge clock_i);
        chk_lvl(locked_o, 1'b0, "lock kept after miss");
        vp(1'b0);
        // Digital window length and timer speed
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h07, lkd(3'h0, 1'b1, 1'b1, lens[k][2:0], spds[k][1:0], 1'b0));
            repeat (5) pair(20);
            chk_lvl(locked_o, hits[k], "window result");
        end
        repeat (6) @(posedge clock_i);
        chk_lvl(rd_q.size() + cal_q.size() == 0, 1'b1, "results missing");
        results();
    end
endmodule // tb_sdlcfg_top

`default_nettype wire
